// ==== hw/command_decode.v ====
// decodes a run command code into one-hot command strobes
`timescale 1ns/100ps
`default_nettype none
`include "drive_comm_map.vh"

module command_decode (
  input  wire [15:0]           code,
  output wire                  codeValid,
  output wire [`CMD_COUNT-1:0] codeOneHot
);

  genvar i;
  generate
    for (i = 0; i < `CMD_COUNT; i = i + 1) begin : gCmd
      assign codeOneHot[i] = (code == (`CMD_FIRST + i[15:0]));
    end
  endgenerate

  assign codeValid = |codeOneHot;

endmodule
`default_nettype wire

// ==== hw/drive_comm_control_status_map.v ====
// communication register bank that controls and reports the drive
`timescale 1ns/100ps
`default_nettype none
`include "drive_comm_map.vh"

module drive_comm_control_status_map #(
  parameter [15:0] MAX_FREQ = 16'd50000
) (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        reqValid,
  input  wire [7:0]  reqFunc,
  input  wire [15:0] reqAddr,
  input  wire [15:0] reqData,
  input  wire        commRunEnable,
  input  wire        commSetEnable,
  input  wire        driveRunning,
  input  wire        driveReverse,
  input  wire        driveFault,
  input  wire        powerOffState,
  input  wire        preExcited,
  input  wire        readyToRun,
  input  wire [1:0]  activeMotor,
  input  wire        syncMachine,
  input  wire        overloadAlarm,
  input  wire [1:0]  commandSource,
  input  wire [15:0] faultType,
  output reg         rspValid,
  output reg         rspException,
  output reg  [15:0] rspData,
  output reg  [7:0]  cmdStrobe,
  output reg  [15:0] freqSetpoint,
  output reg  [15:0] pidSetpoint,
  output reg  [15:0] pidFeedback,
  output reg  [15:0] torqueSetpoint,
  output reg  [15:0] fwdFreqLimit,
  output reg  [15:0] revFreqLimit,
  output reg  [15:0] motTorqueLimit,
  output reg  [15:0] brkTorqueLimit,
  output reg  [1:0]  motorSelect,
  output reg         torqueCtrlDisable,
  output reg         energyClear,
  output reg         preExciteReq,
  output reg         dcBrakeReq,
  output reg  [8:0]  virtualInputs,
  output reg  [3:0]  virtualOutputs,
  output reg  [15:0] voltageSetpoint,
  output reg  [15:0] analogOutputOne,
  output reg  [15:0] analogOutputTwo
);

  // control register storage, indexed by offset minus base
  reg  [15:0] ctrlMem [0:`CTRL_REG_COUNT-1];

  wire        cmdCodeValid;
  wire [7:0]  cmdOneHot;
  wire [15:0] runStateWord;
  wire [15:0] driveCondWord;
  wire [3:0]  ctrlIdx;
  wire        isCtrl;
  wire        isStatus;
  wire        isRead;
  wire        isWrite;
  wire [15:0] specialWord;
  wire        acceptWrite;
  wire        runCmdHit;
  wire        energyClrHit;
  wire [`CTRL_REG_COUNT-1:0] entryWrite;

  reg         valueOk;
  reg         doWrite;
  reg         excNext;
  reg  [7:0]  excCodeNext;
  reg  [15:0] readNext;
  reg  [15:0] statusRead;

  integer     k;
  genvar      j;

  assign ctrlIdx  = reqAddr[3:0];
  assign isCtrl   = (reqAddr >= `ADDR_RUN_COMMAND) &&
                    (reqAddr <= `ADDR_ANALOG_OUT_TWO);
  assign isStatus = (reqAddr >= `ADDR_RUN_STATE_WORD) &&
                    (reqAddr <= `ADDR_FAULT_TYPE);
  assign isRead   = (reqFunc == `FUNC_READ_HOLDING);
  assign isWrite  = (reqFunc == `FUNC_WRITE_SINGLE);
  assign specialWord = ctrlMem[`IDX_SPECIAL_CTRL];

  // accepted writes, and the ones that also fire a side effect
  assign acceptWrite  = reqValid && doWrite;
  assign runCmdHit    = acceptWrite && commRunEnable &&
                        (ctrlIdx == `IDX_RUN_COMMAND);
  assign energyClrHit = acceptWrite && commSetEnable &&
                        (ctrlIdx == `IDX_SPECIAL_CTRL) &&
                        reqData[`SPC_ENERGY_CLR_BIT];

  // one write enable per control register, so a refused write hits none
  generate
    for (j = 0; j < `CTRL_REG_COUNT; j = j + 1) begin : gEntry
      assign entryWrite[j] = acceptWrite && (ctrlIdx == j[3:0]);
    end
  endgenerate

  command_decode uCmd (
    .code       (reqData),
    .codeValid  (cmdCodeValid),
    .codeOneHot (cmdOneHot)
  );

  status_word_pack uStat (
    .driveRunning  (driveRunning),
    .driveReverse  (driveReverse),
    .driveFault    (driveFault),
    .powerOffState (powerOffState),
    .preExcited    (preExcited),
    .readyToRun    (readyToRun),
    .activeMotor   (activeMotor),
    .syncMachine   (syncMachine),
    .overloadAlarm (overloadAlarm),
    .commandSource (commandSource),
    .runStateWord  (runStateWord),
    .driveCondWord (driveCondWord)
  );

  // range check of a value written to a control register
  always @* begin
    valueOk = 1'b0;
    case (ctrlIdx)
      `IDX_RUN_COMMAND: begin
        valueOk = cmdCodeValid;
      end
      `IDX_FREQ_SETPOINT: begin
        valueOk = (reqData <= MAX_FREQ);
      end
      `IDX_PID_SETPOINT: begin
        valueOk = (reqData <= `PID_MAX);
      end
      `IDX_PID_FEEDBACK: begin
        valueOk = (reqData <= `PID_MAX);
      end
      `IDX_TORQUE_SETPOINT: begin
        valueOk = ($signed(reqData) >= $signed(`TORQUE_MIN)) &&
                  ($signed(reqData) <= $signed(`TORQUE_MAX));
      end
      `IDX_FWD_FREQ_LIMIT: begin
        valueOk = (reqData <= MAX_FREQ);
      end
      `IDX_REV_FREQ_LIMIT: begin
        valueOk = (reqData <= MAX_FREQ);
      end
      `IDX_MOT_TORQUE_LIM: begin
        valueOk = (reqData <= `TORQUE_LIMIT_MAX);
      end
      `IDX_BRK_TORQUE_LIM: begin
        valueOk = (reqData <= `TORQUE_LIMIT_MAX);
      end
      `IDX_SPECIAL_CTRL: begin
        valueOk = (reqData <= `SPECIAL_CTRL_MAX);
      end
      `IDX_VIRT_INPUTS: begin
        valueOk = (reqData <= `VIRT_INPUT_MAX);
      end
      `IDX_VIRT_OUTPUTS: begin
        valueOk = (reqData <= `VIRT_OUTPUT_MAX);
      end
      `IDX_VOLT_SETPOINT: begin
        valueOk = (reqData <= `VOLT_MAX);
      end
      `IDX_ANALOG_OUT_ONE, `IDX_ANALOG_OUT_TWO: begin
        valueOk = ($signed(reqData) >= $signed(`ANALOG_MIN)) &&
                  ($signed(reqData) <= $signed(`ANALOG_MAX));
      end
      default: begin
        valueOk = 1'b0;
      end
    endcase
  end

  // status words seen by a read, selected by address
  always @* begin
    statusRead = 16'h0000;
    case (reqAddr)
      `ADDR_RUN_STATE_WORD: begin
        statusRead = runStateWord;
      end
      `ADDR_DRIVE_COND_WORD: begin
        statusRead = driveCondWord;
      end
      `ADDR_FAULT_TYPE: begin
        statusRead = faultType;
      end
      default: begin
        statusRead = 16'h0000;
      end
    endcase
  end

  // request decode: read data, write permission and exception code
  always @* begin
    doWrite     = 1'b0;
    excNext     = 1'b0;
    excCodeNext = 8'h00;
    readNext    = 16'h0000;
    if (isRead) begin
      if (isCtrl) begin
        readNext = ctrlMem[ctrlIdx];
      end else if (isStatus) begin
        readNext = statusRead;
      end else begin
        excNext     = 1'b1;
        excCodeNext = `EXC_ILLEGAL_ADDR;
      end
    end else if (isWrite) begin
      // control registers are written one at a time
      if (isStatus) begin
        excNext     = 1'b1;
        excCodeNext = `EXC_ILLEGAL_ADDR;
      end else if (!isCtrl) begin
        excNext     = 1'b1;
        excCodeNext = `EXC_ILLEGAL_ADDR;
      end else if (!valueOk) begin
        excNext     = 1'b1;
        excCodeNext = `EXC_ILLEGAL_VALUE;
      end else begin
        doWrite = 1'b1;
      end
    end else begin
      excNext     = 1'b1;
      excCodeNext = `EXC_ILLEGAL_FUNC;
    end
  end

  // register storage and response
  always @(posedge ref_clk) begin
    if (!rstn) begin
      for (k = 0; k < `CTRL_REG_COUNT; k = k + 1) begin
        ctrlMem[k] <= `CTRL_RESET;
      end
      rspValid     <= 1'b0;
      rspException <= 1'b0;
      rspData      <= 16'h0000;
    end else begin
      for (k = 0; k < `CTRL_REG_COUNT; k = k + 1) begin
        if (entryWrite[k]) begin
          ctrlMem[k] <= reqData;
        end
      end
      rspValid <= reqValid;
      if (reqValid) begin
        rspException <= excNext;
        if (excNext) begin
          rspData <= {8'h00, excCodeNext};
        end else if (isWrite) begin
          rspData <= reqData;
        end else begin
          rspData <= readNext;
        end
      end
    end
  end

  // command strobes (with commRunEnable) and energy clear (with commSetEnable) act at once on an accepted write
  always @(posedge ref_clk) begin
    if (!rstn) begin
      cmdStrobe   <= 8'h00;
      energyClear <= 1'b0;
    end else begin
      if (runCmdHit) begin
        cmdStrobe <= cmdOneHot;
      end else begin
        cmdStrobe <= 8'h00;
      end
      energyClear <= energyClrHit;
    end
  end

  // setpoints follow the stored values only while commSetEnable is high
  always @(posedge ref_clk) begin
    if (!rstn) begin
      freqSetpoint      <= `CTRL_RESET;
      pidSetpoint       <= `CTRL_RESET;
      pidFeedback       <= `CTRL_RESET;
      torqueSetpoint    <= `CTRL_RESET;
      fwdFreqLimit      <= `CTRL_RESET;
      revFreqLimit      <= `CTRL_RESET;
      motTorqueLimit    <= `CTRL_RESET;
      brkTorqueLimit    <= `CTRL_RESET;
      motorSelect       <= 2'b00;
      torqueCtrlDisable <= 1'b0;
      preExciteReq      <= 1'b0;
      dcBrakeReq        <= 1'b0;
      virtualInputs     <= 9'h000;
      virtualOutputs    <= 4'h0;
      voltageSetpoint   <= `CTRL_RESET;
      analogOutputOne   <= `CTRL_RESET;
      analogOutputTwo   <= `CTRL_RESET;
    end else if (commSetEnable) begin
      freqSetpoint      <= ctrlMem[`IDX_FREQ_SETPOINT];
      pidSetpoint       <= ctrlMem[`IDX_PID_SETPOINT];
      pidFeedback       <= ctrlMem[`IDX_PID_FEEDBACK];
      torqueSetpoint    <= ctrlMem[`IDX_TORQUE_SETPOINT];
      fwdFreqLimit      <= ctrlMem[`IDX_FWD_FREQ_LIMIT];
      revFreqLimit      <= ctrlMem[`IDX_REV_FREQ_LIMIT];
      motTorqueLimit    <= ctrlMem[`IDX_MOT_TORQUE_LIM];
      brkTorqueLimit    <= ctrlMem[`IDX_BRK_TORQUE_LIM];
      motorSelect       <= specialWord[`SPC_MOTOR_LSB+:2];
      torqueCtrlDisable <= specialWord[`SPC_TORQUE_DIS_BIT];
      preExciteReq      <= specialWord[`SPC_PREEXCITE_BIT];
      dcBrakeReq        <= specialWord[`SPC_DC_BRAKE_BIT];
      virtualInputs     <= ctrlMem[`IDX_VIRT_INPUTS][8:0];
      virtualOutputs    <= ctrlMem[`IDX_VIRT_OUTPUTS][3:0];
      voltageSetpoint   <= ctrlMem[`IDX_VOLT_SETPOINT];
      analogOutputOne   <= ctrlMem[`IDX_ANALOG_OUT_ONE];
      analogOutputTwo   <= ctrlMem[`IDX_ANALOG_OUT_TWO];
    end
  end

endmodule
`default_nettype wire

// ==== hw/drive_comm_map.vh ====
// register offsets, field positions and codes of the drive comm bank
`ifndef DRIVE_COMM_MAP_VH
`define DRIVE_COMM_MAP_VH

// control register offsets
`define ADDR_RUN_COMMAND     16'h2000
`define ADDR_FREQ_SETPOINT   16'h2001
`define ADDR_PID_SETPOINT    16'h2002
`define ADDR_PID_FEEDBACK    16'h2003
`define ADDR_TORQUE_SETPOINT 16'h2004
`define ADDR_FWD_FREQ_LIMIT  16'h2005
`define ADDR_REV_FREQ_LIMIT  16'h2006
`define ADDR_MOT_TORQUE_LIM  16'h2007
`define ADDR_BRK_TORQUE_LIM  16'h2008
`define ADDR_SPECIAL_CTRL    16'h2009
`define ADDR_VIRT_INPUTS     16'h200a
`define ADDR_VIRT_OUTPUTS    16'h200b
`define ADDR_VOLT_SETPOINT   16'h200c
`define ADDR_ANALOG_OUT_ONE  16'h200d
`define ADDR_ANALOG_OUT_TWO  16'h200e
// status register offsets
`define ADDR_RUN_STATE_WORD  16'h2100
`define ADDR_DRIVE_COND_WORD 16'h2101
`define ADDR_FAULT_TYPE      16'h2102

// storage index of the control registers (offset minus base)
`define IDX_RUN_COMMAND      4'h0
`define IDX_FREQ_SETPOINT    4'h1
`define IDX_PID_SETPOINT     4'h2
`define IDX_PID_FEEDBACK     4'h3
`define IDX_TORQUE_SETPOINT  4'h4
`define IDX_FWD_FREQ_LIMIT   4'h5
`define IDX_REV_FREQ_LIMIT   4'h6
`define IDX_MOT_TORQUE_LIM   4'h7
`define IDX_BRK_TORQUE_LIM   4'h8
`define IDX_SPECIAL_CTRL     4'h9
`define IDX_VIRT_INPUTS      4'ha
`define IDX_VIRT_OUTPUTS     4'hb
`define IDX_VOLT_SETPOINT    4'hc
`define IDX_ANALOG_OUT_ONE   4'hd
`define IDX_ANALOG_OUT_TWO   4'he
`define CTRL_REG_COUNT       15

// reset value of every control register
`define CTRL_RESET           16'h0000

// serial function codes and exception codes
`define FUNC_READ_HOLDING    8'h03
`define FUNC_WRITE_SINGLE    8'h06
`define EXC_ILLEGAL_FUNC     8'h01
`define EXC_ILLEGAL_ADDR     8'h02
`define EXC_ILLEGAL_VALUE    8'h03

// value limits
`define PID_MAX              16'h03e8
`define TORQUE_MAX           16'h0bb8
`define TORQUE_MIN           16'hf448
`define TORQUE_LIMIT_MAX     16'h0bb8
`define VOLT_MAX             16'h03e8
`define ANALOG_MAX           16'h03e8
`define ANALOG_MIN           16'hfc18
`define VIRT_INPUT_MAX       16'h01ff
`define VIRT_OUTPUT_MAX      16'h000f
`define SPECIAL_CTRL_MAX     16'h003f

// special control word fields
`define SPC_MOTOR_LSB        0
`define SPC_TORQUE_DIS_BIT   2
`define SPC_ENERGY_CLR_BIT   3
`define SPC_PREEXCITE_BIT    4
`define SPC_DC_BRAKE_BIT     5

// run command codes
`define CMD_FIRST            16'h0001
`define CMD_COUNT            8

// run state codes
`define STATE_FORWARD        16'h0001
`define STATE_REVERSE        16'h0002
`define STATE_STOPPED        16'h0003
`define STATE_FAULT          16'h0004
`define STATE_POWER_OFF      16'h0005
`define STATE_PREEXCITED     16'h0006

// drive condition word fields
`define COND_READY_BIT       0
`define COND_MOTOR_LSB       1
`define COND_SYNC_BIT        3
`define COND_OVERLOAD_BIT    4
`define COND_SOURCE_LSB      5

`endif

// ==== hw/status_word_pack.v ====
// builds the run state word and the drive condition word
`timescale 1ns/100ps
`default_nettype none
`include "drive_comm_map.vh"

module status_word_pack (
  input  wire        driveRunning,
  input  wire        driveReverse,
  input  wire        driveFault,
  input  wire        powerOffState,
  input  wire        preExcited,
  input  wire        readyToRun,
  input  wire [1:0]  activeMotor,
  input  wire        syncMachine,
  input  wire        overloadAlarm,
  input  wire [1:0]  commandSource,
  output reg  [15:0] runStateWord,
  output reg  [15:0] driveCondWord
);

  // fault outranks power loss, which outranks every running state
  always @* begin
    if (driveFault) begin
      runStateWord = `STATE_FAULT;
    end else if (powerOffState) begin
      runStateWord = `STATE_POWER_OFF;
    end else if (preExcited) begin
      runStateWord = `STATE_PREEXCITED;
    end else if (driveRunning && driveReverse) begin
      runStateWord = `STATE_REVERSE;
    end else if (driveRunning) begin
      runStateWord = `STATE_FORWARD;
    end else begin
      runStateWord = `STATE_STOPPED;
    end
  end

  always @* begin
    driveCondWord = 16'h0000;
    driveCondWord[`COND_READY_BIT] = readyToRun;
    driveCondWord[`COND_MOTOR_LSB+:2] = activeMotor;
    driveCondWord[`COND_SYNC_BIT] = syncMachine;
    driveCondWord[`COND_OVERLOAD_BIT] = overloadAlarm;
    driveCondWord[`COND_SOURCE_LSB+:2] = commandSource;
  end

endmodule
`default_nettype wire

// ==== verif/drive_bus_master.sv ====
// bus master model that issues single register requests
`timescale 1ns/100ps
`default_nettype none
module drive_bus_master (
  input  wire logic        ref_clk,
  input  wire logic        rspValid,
  input  wire logic        rspException,
  input  wire logic [15:0] rspData,
  output logic             reqValid,
  output logic [7:0]       reqFunc,
  output logic [15:0]      reqAddr,
  output logic [15:0]      reqData
);
  initial begin
    reqValid = 1'b0;
    reqFunc = 8'h00;
    reqAddr = 16'h0000;
    reqData = 16'h0000;
  end

  // one word per request, under whatever function code the caller passes
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, d,
                      output logic exc, output logic [15:0] rd);
    @(posedge ref_clk);
    reqValid <= 1'b1;
    reqFunc <= f;
    reqAddr <= a;
    reqData <= d;
    @(posedge ref_clk);
    // released address and data lines show the inverse; reqFunc keeps its value
    reqValid <= 1'b0;
    reqAddr <= ~a;
    reqData <= ~d;
    #1;
    exc = rspValid === 1'b1 ? rspException : 1'bx;
    rd = rspData;
  endtask
endmodule
`default_nettype wire

// ==== verif/drive_comm_control_status_map_chk.sv ====
// assertions on the ports of the drive comm register bank
`timescale 1ns/100ps
`default_nettype none
module drive_comm_chk #(
  parameter [15:0] MAX_FREQ = 16'd50000
) (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        reqValid,
  input wire logic [7:0]  reqFunc,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic        commRunEnable,
  input wire logic        commSetEnable,
  input wire logic        readyToRun,
  input wire logic [1:0]  activeMotor,
  input wire logic        syncMachine,
  input wire logic        overloadAlarm,
  input wire logic [1:0]  commandSource,
  input wire logic        rspValid,
  input wire logic        rspException,
  input wire logic [15:0] rspData,
  input wire logic [7:0]  cmdStrobe,
  input wire logic        energyClear,
  input wire logic [15:0] freqSetpoint,
  input wire logic [15:0] pidSetpoint
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_rsp_follows: assert property (reqValid |=> rspValid)
    else $error("no answer one cycle after a request");
  a_rsp_only_asked: assert property (!reqValid |=> !rspValid)
    else $error("answer without a request");
  a_strobe_code: assert property (reqValid && reqFunc == 8'h06 &&
    reqAddr == 16'h2000 && reqData >= 16'h0001 && reqData <= 16'h0008 &&
    commRunEnable |=> cmdStrobe == (8'h01 << ($past(reqData[2:0]) - 3'h1)))
    else $error("command strobe does not match the code");
  a_strobe_cause: assert property (cmdStrobe != 8'h00 |->
    $past(reqValid && reqAddr == 16'h2000 && commRunEnable))
    else $error("command strobe without an enabled command write");
  a_ro_refused: assert property (reqValid && reqFunc == 8'h06 &&
    reqAddr >= 16'h2100 && reqAddr <= 16'h2102
    |=> rspException && rspData == 16'h0002)
    else $error("write to a status word not refused");
  a_torque_range: assert property (reqValid && reqFunc == 8'h06 &&
    reqAddr == 16'h2004 && ($signed(reqData) > 16'sd3000 ||
    $signed(reqData) < -16'sd3000) |=> rspException && rspData == 16'h0003)
    else $error("torque setpoint out of range not refused");
  a_cond_word: assert property (reqValid && reqFunc == 8'h03 &&
    reqAddr == 16'h2101 |=> !rspException && rspData == {9'h000,
    $past(commandSource), $past(overloadAlarm), $past(syncMachine),
    $past(activeMotor), $past(readyToRun)})
    else $error("condition word does not match its inputs");
  a_energy_pulse: assert property (reqValid && reqFunc == 8'h06 &&
    reqAddr == 16'h2009 && reqData[3] && reqData <= 16'h003f &&
    commSetEnable |=> energyClear)
    else $error("energy clear pulse missing");
  a_freq_follow: assert property (reqValid && reqFunc == 8'h06 &&
    reqAddr == 16'h2001 && reqData <= MAX_FREQ && commSetEnable ##1
    commSetEnable |=> freqSetpoint == $past(reqData, 2))
    else $error("frequency output does not follow the write");
  a_pid_hold: assert property (!commSetEnable |=> $stable(pidSetpoint))
    else $error("setpoint output moved while not enabled");
endmodule
`default_nettype wire

// ==== verif/drive_comm_control_status_map_tb.sv ====
// self-checking bench for the drive comm register bank
`timescale 1ns/100ps
`default_nettype none
module drive_comm_control_status_map_tb;
  localparam [15:0] MAXF = 16'hc350;
  logic        ref_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        commRunEnable = 1'b0;
  logic        commSetEnable = 1'b0;
  logic [4:0]  runIn = 5'h00;
  logic [6:0]  condIn = 7'h00;
  int          fails = 0;
  int          compares = 0;
  int          i;
  logic [15:0] lim [0:13] = '{MAXF, 16'h03e8, 16'h03e8, 16'h0bb8, MAXF,
    MAXF, 16'h0bb8, 16'h0bb8, 16'h003f, 16'h01ff, 16'h000f, 16'h03e8,
    16'h03e8, 16'h03e8};
  logic [4:0]  rs [0:5] = '{5'h1f, 5'h0f, 5'h07, 5'h03, 5'h02, 5'h01};
  logic [15:0] rsExp [0:5] = '{16'h4, 16'h5, 16'h6, 16'h2, 16'h1, 16'h3};
  wire         reqValid, rspValid, rspException, energyClear;
  wire         torqueCtrlDisable, preExciteReq, dcBrakeReq;
  wire [7:0]   reqFunc, cmdStrobe;
  wire [15:0]  reqAddr, reqData, rspData, freqSetpoint, pidSetpoint;
  wire [15:0]  torqueSetpoint, analogOutputOne, analogOutputTwo;
  wire [15:0]  pidFeedback, fwdFreqLimit, revFreqLimit, motTorqueLimit;
  wire [15:0]  brkTorqueLimit, voltageSetpoint;
  wire [8:0]   virtualInputs;
  wire [3:0]   virtualOutputs;
  wire [1:0]   motorSelect;

  always #20 ref_clk = ~ref_clk;

  drive_bus_master u_master (.ref_clk(ref_clk), .rspValid(rspValid),
    .rspException(rspException), .rspData(rspData), .reqValid(reqValid),
    .reqFunc(reqFunc), .reqAddr(reqAddr), .reqData(reqData));

  drive_comm_control_status_map #(.MAX_FREQ(MAXF)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid), .reqFunc(reqFunc),
    .reqAddr(reqAddr), .reqData(reqData), .commRunEnable(commRunEnable),
    .commSetEnable(commSetEnable), .driveFault(runIn[4]),
    .powerOffState(runIn[3]), .preExcited(runIn[2]),
    .driveRunning(runIn[1]), .driveReverse(runIn[0]),
    .readyToRun(condIn[0]), .activeMotor(condIn[2:1]),
    .syncMachine(condIn[3]), .overloadAlarm(condIn[4]),
    .commandSource(condIn[6:5]), .faultType(16'h5a3c),
    .rspValid(rspValid), .rspException(rspException), .rspData(rspData),
    .cmdStrobe(cmdStrobe), .freqSetpoint(freqSetpoint),
    .pidSetpoint(pidSetpoint), .pidFeedback(pidFeedback),
    .torqueSetpoint(torqueSetpoint), .fwdFreqLimit(fwdFreqLimit),
    .revFreqLimit(revFreqLimit), .motTorqueLimit(motTorqueLimit),
    .brkTorqueLimit(brkTorqueLimit),
    .motorSelect(motorSelect), .torqueCtrlDisable(torqueCtrlDisable),
    .energyClear(energyClear), .preExciteReq(preExciteReq),
    .dcBrakeReq(dcBrakeReq), .virtualInputs(virtualInputs),
    .virtualOutputs(virtualOutputs), .voltageSetpoint(voltageSetpoint),
    .analogOutputOne(analogOutputOne), .analogOutputTwo(analogOutputTwo));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares += 1;
    if (got !== exp) begin
      fails += 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic acc(input logic [7:0] f, input logic [15:0] a, d,
                     input logic x, input logic [15:0] e);
    logic        exc;
    logic [15:0] rd;
    u_master.xfer(f, a, d, exc, rd);
    chk({31'h0, exc}, {31'h0, x});
    chk({16'h0, rd}, {16'h0, e});
  endtask

  task automatic settle2;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge ref_clk);
    fails += 1;
    conclude;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    for (i = 0; i < 15; i++)
      acc(8'h03, 16'h2000 + i[15:0], 16'h0, 1'b0, 16'h0000);
    commSetEnable <= 1'b1;
    for (i = 0; i < 14; i++) begin
      acc(8'h06, 16'h2001 + i[15:0], lim[i] + 16'h1, 1'b1, 16'h3);
      acc(8'h06, 16'h2001 + i[15:0], lim[i], 1'b0, lim[i]);
      acc(8'h03, 16'h2001 + i[15:0], 16'h0, 1'b0, lim[i]);
    end
    acc(8'h06, 16'h2004, 16'hf448, 1'b0, 16'hf448);
    acc(8'h06, 16'h2004, 16'hf447, 1'b1, 16'h0003);
    acc(8'h06, 16'h200d, 16'hfc18, 1'b0, 16'hfc18);
    acc(8'h06, 16'h200e, 16'hfc17, 1'b1, 16'h0003);
    settle2;
    chk({freqSetpoint, torqueSetpoint}, {MAXF, 16'hf448});
    chk({analogOutputOne, analogOutputTwo}, {16'hfc18, 16'h03e8});
    chk({14'h0, virtualInputs, virtualOutputs, motorSelect, torqueCtrlDisable,
      preExciteReq, dcBrakeReq}, {14'h0, 9'h1ff, 4'hf, 2'h3, 3'h7});
    chk({pidSetpoint, pidFeedback}, {16'h03e8, 16'h03e8});
    chk({fwdFreqLimit, revFreqLimit}, {MAXF, MAXF});
    chk({motTorqueLimit, brkTorqueLimit}, {16'h0bb8, 16'h0bb8});
    chk({16'h0, voltageSetpoint}, 32'h03e8);
    @(posedge ref_clk);
    commSetEnable <= 1'b0;
    acc(8'h06, 16'h2001, 16'h1234, 1'b0, 16'h1234);
    settle2;
    chk({16'h0, freqSetpoint}, {16'h0, MAXF});
    commSetEnable <= 1'b1;
    settle2;
    settle2;
    chk({16'h0, freqSetpoint}, 32'h1234);
    commRunEnable <= 1'b1;
    for (i = 1; i < 9; i++) begin
      acc(8'h06, 16'h2000, i[15:0], 1'b0, i[15:0]);
      chk({24'h0, cmdStrobe}, 32'h1 << (i - 1));
    end
    acc(8'h06, 16'h2000, 16'h0000, 1'b1, 16'h0003);
    acc(8'h06, 16'h2000, 16'h0009, 1'b1, 16'h0003);
    acc(8'h03, 16'h2000, 16'h0000, 1'b0, 16'h0008);
    @(posedge ref_clk);
    commRunEnable <= 1'b0;
    acc(8'h06, 16'h2000, 16'h0001, 1'b0, 16'h0001);
    chk({24'h0, cmdStrobe}, 32'h0);
    acc(8'h06, 16'h2009, 16'h000d, 1'b0, 16'h000d);
    chk({31'h0, energyClear}, 32'h1);
    settle2;
    chk({26'h0, motorSelect, torqueCtrlDisable, preExciteReq, dcBrakeReq,
      energyClear}, {26'h0, 2'h1, 3'h4, 1'b0});
    acc(8'h06, 16'h2009, 16'h0030, 1'b0, 16'h0030);
    chk({31'h0, energyClear}, 32'h0);
    acc(8'h06, 16'h2100, 16'h0005, 1'b1, 16'h0002);
    acc(8'h06, 16'h2102, 16'h0005, 1'b1, 16'h0002);
    acc(8'h03, 16'h200f, 16'h0000, 1'b1, 16'h0002);
    acc(8'h10, 16'h2001, 16'h0000, 1'b1, 16'h0001);
    for (i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      runIn <= rs[i];
      acc(8'h03, 16'h2100, 16'h0000, 1'b0, rsExp[i]);
    end
    @(posedge ref_clk);
    condIn <= 7'h55;
    acc(8'h03, 16'h2101, 16'h0000, 1'b0, 16'h0055);
    @(posedge ref_clk);
    condIn <= 7'h2a;
    acc(8'h03, 16'h2101, 16'h0000, 1'b0, 16'h002a);
    acc(8'h03, 16'h2102, 16'h0000, 1'b0, 16'h5a3c);
    conclude;
  end
endmodule

bind drive_comm_control_status_map drive_comm_chk #(.MAX_FREQ(MAX_FREQ))
  u_chk (.ref_clk(ref_clk), .rstn(rstn), .reqValid(reqValid),
  .reqFunc(reqFunc), .reqAddr(reqAddr), .reqData(reqData),
  .commRunEnable(commRunEnable), .commSetEnable(commSetEnable),
  .readyToRun(readyToRun), .activeMotor(activeMotor),
  .syncMachine(syncMachine), .overloadAlarm(overloadAlarm),
  .commandSource(commandSource), .rspValid(rspValid),
  .rspException(rspException), .rspData(rspData), .cmdStrobe(cmdStrobe),
  .energyClear(energyClear), .freqSetpoint(freqSetpoint),
  .pidSetpoint(pidSetpoint));
`default_nettype wire
